// file: pkg/lcdc_pkg.sv
// Constants shared by the LCD duty and pin configuration block
`default_nettype none
package lcdc_pkg;
  // Register bus
  localparam int unsigned ADR_W = 4;
  localparam logic [3:0] OFS_PIN_CTRL = 4'h0;
  localparam logic [3:0] OFS_SHOW_MEMORY_CONTENTS_CTRL = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // Reset values
  localparam logic [7:0] PIN_CTRL_RST = 8'h00;
  localparam logic [7:0] SHOW_MEMORY_CONTENTS_CTRL_RST = 8'h80;
  // Pin-function control fields
  localparam int unsigned DUTY_HI_POS = 7;
  localparam int unsigned DUTY_LO_POS = 6;
  localparam int unsigned CPAR_POS = 5;
  localparam int unsigned EXP_POS = 4;
  localparam int unsigned SGS_MSB = 3;
  // Display control fields
  localparam int unsigned FIXED_ONE_POS = 7;
  localparam int unsigned PSW_POS = 6;
  localparam int unsigned ACT_POS = 5;
  localparam int unsigned SHOW_POS = 4;
  localparam int unsigned CKS_MSB = 3;
  // Duty encodings
  typedef enum logic [1:0] {
    LCDC_DUTY_STATIC  = 2'h0,
    LCDC_DUTY_HALF    = 2'h1,
    LCDC_DUTY_THIRD   = 2'h2,
    LCDC_DUTY_QUARTER = 2'h3
  } lcdc_duty_t;
  // Common source codes packed {com4,com3,com2,com1}
  localparam logic [7:0] COM_SRC_IDENT = 8'hE4;
  localparam logic [7:0] COM_SRC_STATIC = 8'h00;
  localparam logic [7:0] COM_SRC_HALF = 8'hA0;
  // System clock prescaler
  localparam int unsigned SYS_CNT_W = 8;
  localparam logic [7:0] SYS_MASK_ALL = 8'hFF;
endpackage
`default_nettype wire

// file: pkg/lcdc_cfg_if.sv
// Carrier between the control core and the two pin mapping modules
`timescale 1ns/1ps
`default_nettype none
interface lcdc_cfg_if;
  logic [7:0] pin_ctrl;
  logic [3:0] com_used;
  logic [7:0] com_src;
  logic [4:0] seg_group_on;
  logic       exp_pins_on;
  logic       top_pins_port;
  logic       forbidden;
  modport ctrl (output pin_ctrl, input com_used, com_src, seg_group_on,
                input exp_pins_on, top_pins_port, forbidden);
  modport com (input pin_ctrl, output com_used, com_src);
  modport seg (input pin_ctrl, output seg_group_on, exp_pins_on,
               output top_pins_port, forbidden);
endinterface
`default_nettype wire

// file: rtl/lcdc_com_map.sv
// Common output usage and mirroring by duty
`timescale 1ns/1ps
`default_nettype none
module lcdc_com_map (
  // Configuration carrier
  lcdc_cfg_if.com cfg
);
  logic [1:0] duty;
  logic       cpar;

  assign duty = cfg.pin_ctrl[lcdc_pkg::DUTY_HI_POS:lcdc_pkg::DUTY_LO_POS];
  assign cpar = cfg.pin_ctrl[lcdc_pkg::CPAR_POS];

  always_comb begin
    cfg.com_src = lcdc_pkg::COM_SRC_IDENT;
    case (lcdc_pkg::lcdc_duty_t'(duty))
      lcdc_pkg::LCDC_DUTY_STATIC: begin
        // All four carry common one when mirrored
        cfg.com_used = cpar ? 4'hF : 4'h1;
        cfg.com_src = lcdc_pkg::COM_SRC_STATIC;
      end
      lcdc_pkg::LCDC_DUTY_HALF: begin
        cfg.com_used = cpar ? 4'hF : 4'h3;
        if (cpar) begin
          cfg.com_src = lcdc_pkg::COM_SRC_HALF;
        end
      end
      // Mirroring has no spare partner at 1/3, fourth stays idle
      lcdc_pkg::LCDC_DUTY_THIRD: cfg.com_used = 4'h7;
      lcdc_pkg::LCDC_DUTY_QUARTER: cfg.com_used = 4'hF;
      default: cfg.com_used = 4'h1;
    endcase
  end
endmodule
`default_nettype wire

// file: rtl/lcdc_seg_map.sv
// Segment pin group function and expansion pin selection
`timescale 1ns/1ps
`default_nettype none
module lcdc_seg_map (
  // Configuration carrier
  lcdc_cfg_if.seg cfg
);
  logic [3:0] sgs;
  logic       exp;
  logic [2:0] level;

  assign sgs = cfg.pin_ctrl[lcdc_pkg::SGS_MSB:0];
  assign exp = cfg.pin_ctrl[lcdc_pkg::EXP_POS];

  // Number of groups driven as segments, counted from the top
  always_comb begin
    if (exp) begin
      level = 3'h0;
    end else if (sgs[3]) begin
      level = 3'h5;
    end else if (sgs[2:1] != 2'h0) begin
      level = 3'(sgs[2:1]) + 3'h1;
    end else begin
      level = 3'(sgs[0]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gen_group
      assign cfg.seg_group_on[g] = (level >= 3'(5 - g));
    end
  endgenerate

  // Forbidden combination turns off every segment group and the expansion pins, and also holds top_pins_port low
  assign cfg.forbidden = exp && (sgs != 4'h0);
  assign cfg.exp_pins_on = exp && (sgs == 4'h0);
  assign cfg.top_pins_port = !exp && (sgs == 4'h0);
endmodule
`default_nettype wire

// file: rtl/lcdc_top.sv
// LCD duty and pin configuration registers with frame clock select
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module lcdc_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Subclock tick, one cycle per subclock period
  input  wire logic        sub_tick,
  // Common drive selection
  output logic      [1:0]  duty_sel,
  output logic      [3:0]  com_used,
  output logic      [7:0]  com_src,
  // Segment pin functions
  output logic      [4:0]  seg_group_on,
  output logic             exp_pins_on,
  output logic             top_pins_port,
  output logic             cfg_forbidden,
  // Display control
  output logic             ctrl_run,
  output logic             drive_power_on,
  output logic             show_memory_contents,
  output logic             frame_from_subclock,
  output logic             frame_tick
);
  lcdc_cfg_if cfg ();

  logic [7:0]  pin_ctrl;
  logic [6:0]  show_memory_contents_ctrl;
  logic [7:0]  next_pin_ctrl;
  logic [6:0]  next_show_memory_contents_ctrl;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        req;
  logic [7:0]  show_memory_contents_rd;

  logic [7:0]  sys_cnt;
  logic [1:0]  sub_cnt;
  logic [7:0]  next_sys_cnt;
  logic [1:0]  next_sub_cnt;
  logic [7:0]  sys_mask;
  logic [1:0]  sub_mask;
  logic        act;
  logic [3:0]  cks;

  logic [1:0]  next_duty_sel;
  logic [3:0]  next_com_used;
  logic [7:0]  next_com_src;
  logic [4:0]  next_seg_group_on;
  logic        next_exp_pins_on;
  logic        next_top_pins_port;
  logic        next_forbidden;
  logic        next_run;
  logic        next_power;
  logic        next_show;
  logic        next_from_sub;
  logic        next_tick;

  assign cfg.pin_ctrl = pin_ctrl;

  lcdc_com_map u_com (
    .cfg (cfg)
  );

  lcdc_seg_map u_seg (
    .cfg (cfg)
  );

  // Bit 7 has no storage and always reads one
  assign show_memory_contents_rd = {1'b1, show_memory_contents_ctrl};
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign act = show_memory_contents_ctrl[lcdc_pkg::ACT_POS];
  assign cks = show_memory_contents_ctrl[lcdc_pkg::CKS_MSB:0];

  // Register file and bus answer
  always_comb begin
    next_pin_ctrl = pin_ctrl;
    next_show_memory_contents_ctrl = show_memory_contents_ctrl;
    next_ack = req;
    next_dat = 32'h0000_0000;
    if (req) begin
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == lcdc_pkg::OFS_PIN_CTRL) begin
          next_pin_ctrl = wb_dat_i[7:0];
        end else if (wb_adr_i == lcdc_pkg::OFS_SHOW_MEMORY_CONTENTS_CTRL) begin
          next_show_memory_contents_ctrl = wb_dat_i[6:0];
        end
      end
      if (!wb_we_i) begin
        case (wb_adr_i)
          lcdc_pkg::OFS_PIN_CTRL: next_dat = {24'h00_0000, pin_ctrl};
          lcdc_pkg::OFS_SHOW_MEMORY_CONTENTS_CTRL: next_dat = {24'h00_0000, show_memory_contents_rd};
          lcdc_pkg::OFS_STATUS: next_dat = {31'h0, cfg.forbidden};
          default: next_dat = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_ctrl <= lcdc_pkg::PIN_CTRL_RST;
      show_memory_contents_ctrl <= lcdc_pkg::SHOW_MEMORY_CONTENTS_CTRL_RST[6:0];
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      pin_ctrl <= next_pin_ctrl;
      show_memory_contents_ctrl <= next_show_memory_contents_ctrl;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // Frame clock prescalers; both stop while the controller is halted
  always_comb begin
    sys_mask = lcdc_pkg::SYS_MASK_ALL >> (3'h7 - cks[2:0]);
    sub_mask = cks[1] ? 2'h3 : {1'b0, cks[0]};
    next_sys_cnt = act ? sys_cnt + 8'h01 : 8'h00;
    next_sub_cnt = sub_cnt;
    if (!act) begin
      next_sub_cnt = 2'h0;
    end else if (sub_tick) begin
      next_sub_cnt = sub_cnt + 2'h1;
    end
    next_from_sub = !cks[3];
    if (!act) begin
      next_tick = 1'b0;
    end else if (cks[3]) begin
      next_tick = (sys_cnt & sys_mask) == sys_mask;
    end else begin
      next_tick = sub_tick && ((sub_cnt & sub_mask) == sub_mask);
    end
    next_duty_sel = pin_ctrl[lcdc_pkg::DUTY_HI_POS:lcdc_pkg::DUTY_LO_POS];
    next_com_used = cfg.com_used;
    next_com_src = cfg.com_src;
    next_seg_group_on = cfg.seg_group_on;
    next_exp_pins_on = cfg.exp_pins_on;
    next_top_pins_port = cfg.top_pins_port;
    next_forbidden = cfg.forbidden;
    next_run = act;
    // Power needs both the switch and the activate bit
    next_power = act && show_memory_contents_ctrl[lcdc_pkg::PSW_POS];
    next_show = show_memory_contents_ctrl[lcdc_pkg::SHOW_POS];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sys_cnt <= 8'h00;
      sub_cnt <= 2'h0;
      duty_sel <= 2'h0;
      com_used <= 4'h1;
      com_src <= lcdc_pkg::COM_SRC_STATIC;
      seg_group_on <= 5'h00;
      exp_pins_on <= 1'b0;
      top_pins_port <= 1'b1;
      cfg_forbidden <= 1'b0;
      ctrl_run <= 1'b0;
      drive_power_on <= 1'b0;
      show_memory_contents <= 1'b0;
      frame_from_subclock <= 1'b1;
      frame_tick <= 1'b0;
    end else begin
      sys_cnt <= next_sys_cnt;
      sub_cnt <= next_sub_cnt;
      duty_sel <= next_duty_sel;
      com_used <= next_com_used;
      com_src <= next_com_src;
      seg_group_on <= next_seg_group_on;
      exp_pins_on <= next_exp_pins_on;
      top_pins_port <= next_top_pins_port;
      cfg_forbidden <= next_forbidden;
      ctrl_run <= next_run;
      drive_power_on <= next_power;
      show_memory_contents <= next_show;
      frame_from_subclock <= next_from_sub;
      frame_tick <= next_tick;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_pin_write: assert property (
    req && wb_we_i && wb_sel_i[0] && wb_adr_i == lcdc_pkg::OFS_PIN_CTRL
    |=> pin_ctrl == $past(wb_dat_i[7:0]))
    else $error("pin control write lost");
  a_show_memory_contents_top_one: assert property (
    req && !wb_we_i && wb_adr_i == lcdc_pkg::OFS_SHOW_MEMORY_CONTENTS_CTRL
    |=> wb_ack_o && wb_dat_o[7:0] == {1'b1, $past(show_memory_contents_ctrl)})
    else $error("display control readback wrong");
  a_power_gated: assert property (
    !act |=> !drive_power_on && !ctrl_run && !frame_tick)
    else $error("power or tick while halted");
  a_static_mirror: assert property (
    duty_sel == 2'h0 && com_used == 4'hF |-> com_src == 8'h00)
    else $error("static mirror source wrong");
  a_half_mirror: assert property (
    duty_sel == 2'h1 |-> com_used == 4'h3 ||
    (com_used == 4'hF && com_src == 8'hA0))
    else $error("half duty commons wrong");
  a_third_idle: assert property (
    duty_sel == 2'h2 |-> com_used == 4'h7)
    else $error("fourth common used at 1/3 duty");
  a_exp_only_zero: assert property (
    exp_pins_on |-> seg_group_on == 5'h00 && $past(pin_ctrl[3:0]) == 4'h0)
    else $error("expansion with segment groups");
  a_groups_top: assert property (
    seg_group_on inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F})
    else $error("segment groups not from the top");
  a_top_port: assert property (
    top_pins_port |-> !exp_pins_on && !seg_group_on[4])
    else $error("top pins port while otherwise used");
  a_div2_tick: assert property (
    frame_tick && act && cks == 4'h8 && $stable(show_memory_contents_ctrl) |=> !frame_tick)
    else $error("system clock /2 tick too dense");
  a_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_pin_read: assert property (
    req && !wb_we_i && wb_adr_i == lcdc_pkg::OFS_PIN_CTRL
    |=> wb_dat_o == {24'h00_0000, $past(pin_ctrl)})
    else $error("pin control readback wrong");
  a_show_memory_contents_write: assert property (
    req && wb_we_i && wb_sel_i[0] && wb_adr_i == lcdc_pkg::OFS_SHOW_MEMORY_CONTENTS_CTRL
    |=> show_memory_contents_ctrl == $past(wb_dat_i[6:0]))
    else $error("display control write lost");
  a_lane_guard: assert property (
    req && wb_we_i && !wb_sel_i[0]
    |=> $stable(pin_ctrl) && $stable(show_memory_contents_ctrl))
    else $error("write without lane zero landed");
  a_duty_copy: assert property (
    1'b1 |=> duty_sel == $past(pin_ctrl[7:6]))
    else $error("duty select not following register");
  a_quarter_all: assert property (
    duty_sel == 2'h3
    |-> com_used == 4'hF && com_src == lcdc_pkg::COM_SRC_IDENT)
    else $error("quarter duty commons wrong");
  a_static_single: assert property (
    duty_sel == 2'h0
    |-> com_used inside {4'h1, 4'hF} && com_src == lcdc_pkg::COM_SRC_STATIC)
    else $error("static commons wrong");
  a_static_plain: assert property (
    pin_ctrl[7:5] == 3'h0 |=> com_used == 4'h1)
    else $error("static drive uses spare commons");
  a_static_par: assert property (
    pin_ctrl[7:5] == 3'h1 |=> com_used == 4'hF)
    else $error("static mirror not on all commons");
  a_half_plain: assert property (
    pin_ctrl[7:5] == 3'h2 |=> com_used == 4'h3)
    else $error("half duty uses spare commons");
  a_half_par: assert property (
    pin_ctrl[7:5] == 3'h3
    |=> com_used == 4'hF && com_src == lcdc_pkg::COM_SRC_HALF)
    else $error("half duty mirror wrong");
  a_exp_follow: assert property (
    pin_ctrl[4:0] == 5'h10 |=> exp_pins_on && !cfg_forbidden)
    else $error("expansion pins not selected");
  a_forbid_flag: assert property (
    pin_ctrl[4] && pin_ctrl[3:0] != 4'h0
    |=> cfg_forbidden && !exp_pins_on && seg_group_on == 5'h00)
    else $error("forbidden setting not held safe");
  a_port_follow: assert property (
    pin_ctrl[4:0] == 5'h00 |=> top_pins_port && seg_group_on == 5'h00)
    else $error("top pins not ports");
  a_all_groups: assert property (
    !pin_ctrl[4] && pin_ctrl[3] |=> seg_group_on == 5'h1F)
    else $error("not all segment groups enabled");
  a_power_on: assert property (
    act && show_memory_contents_ctrl[lcdc_pkg::PSW_POS] |=> drive_power_on && ctrl_run)
    else $error("drive power not switched on");
  a_halt_counts: assert property (
    !act |=> sys_cnt == 8'h00 && sub_cnt == 2'h0)
    else $error("prescaler running while halted");
  a_show_follow: assert property (
    1'b1 |=> show_memory_contents == $past(show_memory_contents_ctrl[lcdc_pkg::SHOW_POS]))
    else $error("display data select not following");
  a_sub_source: assert property (
    1'b1 |=> frame_from_subclock == !$past(cks[3]))
    else $error("frame clock source wrong");
  a_sub_undiv: assert property (
    act && cks == 4'h0 && sub_tick |=> frame_tick)
    else $error("undivided subclock tick missed");
  a_sub_gap: assert property (
    act && !cks[3] && !sub_tick |=> !frame_tick)
    else $error("subclock frame tick without subclock");
endmodule
`default_nettype wire

// file: tb/lcdc_panel_model.sv
// Far-side model: subclock tick source and frame counter
`timescale 1ns/1ps
`default_nettype none
module lcdc_panel_model #(
  parameter int SUB_DIV = 8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Display side
  input  wire logic        frame_tick,
  output logic             sub_tick,
  output logic      [15:0] frames
);
  int unsigned div;
  // Subclock free-runs, as a watch crystal does
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div      <= 0;
      sub_tick <= 1'b0;
      frames   <= 16'h0000;
    end else begin
      div      <= (div == SUB_DIV - 1) ? 0 : div + 1;
      sub_tick <= (div == SUB_DIV - 1);
      frames   <= frames + {15'h0000, frame_tick};
    end
  end
endmodule
`default_nettype wire

// file: tb/lcdc_tb_top.sv
// Self-checking bench for the LCD configuration registers
`timescale 1ns/1ps
`default_nettype none
module lcdc_tb_top;
  logic core_clk, rstn, cyc, stb, we, sub_tick, ack, fst, run, pwr, shw, ftk;
  logic exo, tpp, fbd;
  logic [3:0]  adr, sel, cu;
  logic [31:0] wdat, rdat, rd;
  logic [1:0]  dsel;
  logic [7:0]  csrc;
  logic [4:0]  sgo;
  logic [15:0] frames, f0;
  int fails, cmp_count, cycles;
  logic [3:0] used_t [8] = '{4'h1, 4'hF, 4'h3, 4'hF, 4'h7, 4'h7, 4'hF, 4'hF};
  logic [7:0] src_t  [8] = '{8'h00, 8'h00, 8'h04, 8'hA0, 8'h24, 8'h24,
                             8'hE4, 8'hE4};
  lcdc_top DUT (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sub_tick(sub_tick),
    .duty_sel(dsel), .com_used(cu), .com_src(csrc), .seg_group_on(sgo),
    .exp_pins_on(exo), .top_pins_port(tpp), .cfg_forbidden(fbd),
    .ctrl_run(run), .drive_power_on(pwr), .show_memory_contents(shw),
    .frame_from_subclock(fst), .frame_tick(ftk));
  lcdc_panel_model #(.SUB_DIV(8)) panel (.core_clk(core_clk), .rstn(rstn),
    .frame_tick(ftk), .sub_tick(sub_tick), .frames(frames));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; read data taken at the ack edge
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d, logic [3:0] s);
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s;
    wdat <= {24'h000000, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    #1;
  endtask
  function automatic logic [4:0] seg_exp(logic [3:0] v);
    if (v[3]) return 5'h1F;
    case (v[2:1])
      2'h0: return v[0] ? 5'h10 : 5'h00;
      2'h1: return 5'h18;
      2'h2: return 5'h1C;
      default: return 5'h1E;
    endcase
  endfunction
  initial begin
    logic [7:0] m;
    int p;
    rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0;
    sel = 4'h0; wdat = 32'h0; fails = 0; cmp_count = 0; cycles = 0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    bus(0, 4'h0, 8'h00, 4'hF); chk(rd, 32'h00);
    bus(0, 4'h4, 8'h00, 4'hF); chk(rd, 32'h80);
    chk({cu, tpp, pwr, shw, fst}, {4'h1, 4'h9});
    bus(1, 4'h0, 8'h5A, 4'h0); bus(0, 4'h0, 8'h00, 4'hF);
    chk(rd, 32'h00);
    bus(1, 4'h8, 8'hFF, 4'hF); bus(0, 4'hC, 8'h00, 4'hF);
    chk(rd, 32'h00);
    bus(1, 4'h0, 8'hFF, 4'hF); bus(0, 4'h0, 8'h00, 4'hF); chk(rd, 32'hFF);
    chk({fbd, exo, tpp, sgo}, 8'h80);
    bus(0, 4'h8, 8'h00, 4'hF); chk(rd, 32'h01);
    for (int i = 0; i < 8; i++) begin
      bus(1, 4'h0, {i[2:0], 5'h01}, 4'hF);
      for (int k = 0; k < 4; k++) m[2*k +: 2] = {2{cu[k]}};
      chk({dsel, cu, csrc & m}, {i[2:1], used_t[i], src_t[i]});
    end
    for (int v = 0; v < 32; v++) begin
      bus(1, 4'h0, {3'h0, v[4:0]}, 4'hF);
      if (!v[4]) chk({exo, fbd, tpp, sgo}, {2'h0, v[3:0] == 0,
                     seg_exp(v[3:0])});
      else chk({exo, fbd, tpp, sgo}, {v[3:0] == 0, v[3:0] != 0, 6'h00});
    end
    // Expansion left at zero afterwards, as software must
    bus(1, 4'h0, 8'h00, 4'hF);
    bus(1, 4'h4, 8'h7F, 4'hF); bus(0, 4'h4, 8'h00, 4'hF); chk(rd, 32'hFF);
    chk({run, pwr, shw, fst}, 4'hE);
    bus(1, 4'h4, 8'h50, 4'hF); bus(0, 4'h4, 8'h00, 4'hF); chk(rd, 32'hD0);
    chk({run, pwr, shw}, 3'h1);
    f0 = frames;
    repeat (256) @(posedge core_clk);
    chk(frames, f0);
    for (int c = 0; c < 16; c++) begin
      bus(1, 4'h4, {4'h2, c[3:0]}, 4'hF);
      p = c[3] ? (2 << c[2:0]) : (c[1] ? 32 : (c[0] ? 16 : 8));
      chk(fst, !c[3]);
      repeat (256) @(posedge core_clk);
      f0 = frames;
      repeat (512) @(posedge core_clk);
      chk(frames - f0, 512 / p);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
